//--- pkg/ilf_pkg.sv
`default_nettype none
package ilf_pkg;
	localparam int SAMPLE_W = 24;
	localparam int MS_W = 16;
	localparam int LEVEL_W = 4;
	localparam logic [LEVEL_W-1:0] LEVEL_MAX = 4'h8;
	localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h0;
	localparam logic [7:0] MODEL_STANDARD = 8'h00;
	localparam logic [7:0] MODEL_MULTI = 8'h01;
	localparam logic [7:0] MODEL_EXTENDED = 8'h02;
	localparam logic [7:0] MODEL_RESET = 8'h00;
	localparam int RATE_LOW_HZ = 15000;
	localparam int RATE_HIGH_HZ = 20000;
	localparam int CLK_HZ = 40000000;
	localparam int DIV_LOW = CLK_HZ / RATE_LOW_HZ;
	localparam int DIV_HIGH = CLK_HZ / RATE_HIGH_HZ;
	localparam int DIV_W = 12;
	typedef enum logic [1:0] {ILF_IDLE, ILF_CALC, ILF_SEND} ilf_state_type;
endpackage : ilf_pkg
`default_nettype wire

//--- pkg/ilf_cfg_if.sv
`default_nettype none
interface ilf_cfg_if;
	import ilf_pkg::*;
	logic [LEVEL_W-1:0] level;
	logic fir_enable;
	logic apply;
	modport ctrl (output level, output fir_enable, output apply);
	modport core (input level, input fir_enable, input apply);
endinterface : ilf_cfg_if
`default_nettype wire

//--- verilog/ilf_cfg_latch.sv
`default_nettype none
module ilf_cfg_latch
	import ilf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Requested settings
	input wire logic [7:0] function_model,
	input wire logic [ilf_pkg::LEVEL_W-1:0] iir_level_config,
	input wire logic fir_enable_config,
	input wire logic update_tick,
	// Settings seen by the filter
	ilf_cfg_if.ctrl cfg
);
	import ilf_pkg::*;
	logic [LEVEL_W-1:0] level;
	logic fir_en;
	logic apply;
	wire model_ok = (function_model == MODEL_EXTENDED);
	// Levels above the table saturate so the shift stays meaningful.
	wire [LEVEL_W-1:0] lvl_clip = (iir_level_config > LEVEL_MAX) ?
		LEVEL_MAX : iir_level_config;
	wire take = model_ok && update_tick;
	// Settings change only on an update tick so both stages switch together.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			level <= LEVEL_RESET;
			fir_en <= 1'b0;
			apply <= 1'b0;
		end else begin
			apply <= take;
			if (take) begin
				level <= lvl_clip;
				fir_en <= fir_enable_config;
			end
		end
	end
	assign cfg.level = level;
	assign cfg.fir_enable = fir_en;
	assign cfg.apply = apply;
endmodule : ilf_cfg_latch
`default_nettype wire

//--- verilog/ilf_iir_filter.sv
`default_nettype none
// Overview of operation
// - Each converter result is 24 bits and keeps full width through filtering.
// - Samples are signed; 0x7fffff is positive full scale.
// - Multiple-sampling model outputs only the top 16 bits.
// - Two enables set independently at runtime; only the IIR level filters samples, the FIR enable just drives fir_active.
// - After reset both filters are off and samples pass unfiltered.
// - Filter settings are accepted only in extended filter model 2.
// - Settings change only on an update tick and apply to both filters together.
// - New output is old output plus difference over two to the level.
// - Level comes from the common setting; zero disables the filter.
// - First-order filter with levels one through eight.
// - Filter iterates once per I/O update, 15000 or 20000 per second.
module ilf_iir_filter
	import ilf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Converter samples
	input wire logic [ilf_pkg::SAMPLE_W-1:0] sample_in,
	input wire logic sample_valid,
	// Configuration
	input wire logic [7:0] function_model,
	input wire logic [ilf_pkg::LEVEL_W-1:0] iir_level_config,
	input wire logic fir_enable_config,
	input wire logic fast_rate,
	// Filtered output
	output logic [ilf_pkg::SAMPLE_W-1:0] data_out,
	output logic data_valid,
	output logic iir_active,
	output logic fir_active,
	output logic update_tick
);
	import ilf_pkg::*;

	ilf_cfg_if cfg ();
	ilf_state_type state;
	ilf_state_type next_state;
	logic [DIV_W-1:0] div_count;
	logic signed [SAMPLE_W-1:0] x_hold;
	logic signed [SAMPLE_W+1:0] y_state;
	logic [SAMPLE_W-1:0] y_out;
	logic x_fresh;

	// The update divider sets the filter iteration rate.
	wire [DIV_W-1:0] div_top = fast_rate ?
		DIV_W'(DIV_HIGH - 1) : DIV_W'(DIV_LOW - 1);
	wire tick = (div_count == div_top);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			div_count <= '0;
			update_tick <= 1'b0;
		end else begin
			div_count <= tick ? '0 : div_count + 1'b1;
			update_tick <= tick;
		end
	end

	ilf_cfg_latch u_cfg (
		.clk(clk),
		.rst_b(rst_b),
		.function_model(function_model),
		.iir_level_config(iir_level_config),
		.fir_enable_config(fir_enable_config),
		.update_tick(tick),
		.cfg(cfg.ctrl)
	);

	// Newest sample is held; the filter consumes one per update.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			x_hold <= '0;
			x_fresh <= 1'b0;
		end else if (sample_valid) begin
			x_hold <= sample_in;
			x_fresh <= 1'b1;
		end else if (state == ILF_CALC) begin
			x_fresh <= 1'b0;
		end
	end

	// Two guard bits keep the difference from wrapping at full scale.
	wire signed [SAMPLE_W+1:0] x_ext = {{2{x_hold[SAMPLE_W-1]}}, x_hold};
	wire signed [SAMPLE_W+1:0] diff = x_ext - y_state;
	wire signed [SAMPLE_W+1:0] step = diff >>> cfg.level;
	wire iir_on = (cfg.level != '0);
	wire signed [SAMPLE_W+1:0] y_next = iir_on ?
		y_state + step : x_ext;
	wire start = tick && x_fresh;

	always_comb begin
		next_state = state;
		case (state)
			ILF_IDLE: if (start) next_state = ILF_CALC;
			ILF_CALC: next_state = ILF_SEND;
			ILF_SEND: next_state = ILF_IDLE;
			default: next_state = ILF_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state <= ILF_IDLE;
			y_state <= '0;
		end else begin
			state <= next_state;
			if (state == ILF_CALC) y_state <= y_next;
		end
	end

	// The multiple-sampling model drops the low noisy bits of the sample.
	wire multi = (function_model == MODEL_MULTI);
	wire [SAMPLE_W-1:0] y_trim = y_state[SAMPLE_W-1:0];
	assign y_out = multi ?
		{{(SAMPLE_W-MS_W){y_trim[SAMPLE_W-1]}},
		y_trim[SAMPLE_W-1 -: MS_W]} : y_trim;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			data_out <= '0;
			data_valid <= 1'b0;
			iir_active <= 1'b0;
			fir_active <= 1'b0;
		end else begin
			data_valid <= (state == ILF_SEND);
			if (state == ILF_SEND) data_out <= y_out;
			// Both flags move only on a latched setting, so they switch together.
			if (cfg.apply) begin
				iir_active <= iir_on;
				fir_active <= cfg.fir_enable;
			end
		end
	end
endmodule : ilf_iir_filter
`default_nettype wire

//--- tb/ilf_iir_filter_assertions.sv
`default_nettype none
module ilf_chk
	import ilf_pkg::*;
(
	// Watched ports of the filter
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] function_model,
	input wire logic [ilf_pkg::SAMPLE_W-1:0] data_out,
	input wire logic data_valid,
	input wire logic iir_active,
	input wire logic fir_active,
	input wire logic update_tick
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_quiet_reset: assert property (
		!$past(rst_b) |-> !data_valid && !iir_active && data_out == '0)
		else $error("output busy after reset");
	a_valid_after_tick: assert property (
		data_valid |-> $past(update_tick, 2)) else $error("valid off tick");
	a_tick_pulse: assert property (
		update_tick |=> !update_tick [*8]) else $error("tick too long");
	a_valid_once: assert property (
		data_valid |=> !data_valid [*8]) else $error("valid too long");
	a_out_holds: assert property (
		!data_valid |-> $stable(data_out)) else $error("output moved");
	a_iir_on_tick: assert property (
		$changed(iir_active) |-> $past(update_tick)
		&& $past(function_model, 2) == MODEL_EXTENDED) else $error("iir moved");
	a_fir_on_tick: assert property (
		$changed(fir_active) |-> $past(update_tick)
		&& $past(function_model, 2) == MODEL_EXTENDED) else $error("fir moved");
	a_multi_sign: assert property (
		data_valid && $past(function_model) == MODEL_MULTI
		|-> data_out[23:15] inside {9'h000, 9'h1ff}) else $error("not 16 bit");
	c_filtered: cover property (data_valid && iir_active);
	c_multi: cover property (data_valid && function_model == MODEL_MULTI);
	c_fir_on: cover property ($rose(fir_active));
endmodule : ilf_chk
bind ilf_iir_filter ilf_chk u_chk (.clk(clk), .rst_b(rst_b),
	.function_model(function_model), .data_out(data_out),
	.data_valid(data_valid), .iir_active(iir_active),
	.fir_active(fir_active), .update_tick(update_tick));
`default_nettype wire

//--- tb/ilf_adc_model.sv
`default_nettype none
module ilf_adc_model
	import ilf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Value to convert and the converter result
	input wire logic [ilf_pkg::SAMPLE_W-1:0] level_value,
	output logic [ilf_pkg::SAMPLE_W-1:0] sample,
	output logic valid
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// Between results the lines toggle, so a stale sample cannot pass.
	initial begin
		valid = 1'b0;
		sample = '0;
		forever begin
			@(negedge clk);
			cnt = (cnt == 499 || !rst_b) ? 0 : cnt + 1;
			valid = rst_b && cnt == 499;
			sample = valid ? level_value : ~sample;
		end
	end
endmodule : ilf_adc_model
`default_nettype wire

//--- tb/ilf_iir_filter_tb.sv
`default_nettype none
module ilf_iir_filter_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ilf_pkg::*;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %0t %h %h", $time, g, e); end end
	logic clk = 0, rst_b = 0, sv, fir = 0, fast = 0, dv, ia, fa, tick;
	logic [7:0] model = MODEL_EXTENDED;
	logic [LEVEL_W-1:0] lvl = 0;
	logic [SAMPLE_W-1:0] x = 0, si, dout;
	int mismatches = 0, checks = 0, cyc = 0, gap = 0, yi = 0;
	int ticks = 0, t0 = 0;
	initial forever #12.5 clk = ~clk;
	ilf_adc_model adc (.clk(clk), .rst_b(rst_b), .level_value(x),
		.sample(si), .valid(sv));
	ilf_iir_filter dut (.clk(clk), .rst_b(rst_b), .sample_in(si),
		.sample_valid(sv), .function_model(model), .iir_level_config(lvl),
		.fir_enable_config(fir), .fast_rate(fast), .data_out(dout),
		.data_valid(dv), .iir_active(ia), .fir_active(fa), .update_tick(tick));
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			finish_test();
		end
	end
	// Update pulses are counted where they are settled.
	always @(negedge clk) begin
		if (tick === 1'b1) ticks++;
	end
	task automatic next_out;
		gap = 0;
		do begin @(negedge clk); gap++; end while (!dv && gap < 3000);
		`CHK(dv, 1'b1)
	endtask : next_out
	task automatic t_iir;
		x = 24'h7fffff;
		next_out();
		next_out();
		`CHK(dout, 24'h7fffff)
		`CHK(ia, 1'b0)
		lvl = 4'h3;
		next_out();
		next_out();
		`CHK(ia, 1'b1)
		yi = 24'h7fffff;
		x = 24'h800000;
		repeat (3) begin
			next_out();
			yi = yi + (($signed(x) - yi) >>> 3);
			`CHK(dout, yi[23:0])
		end
	endtask : t_iir
	task automatic t_lock;
		model = MODEL_STANDARD;
		lvl = 4'h0;
		fir = 1;
		next_out();
		next_out();
		`CHK({ia, fa}, 2'b10)
		model = MODEL_EXTENDED;
		next_out();
		next_out();
		`CHK({ia, fa}, 2'b01)
		model = MODEL_MULTI;
		x = 24'h876543;
		next_out();
		next_out();
		`CHK(dout, 24'hff8765)
	endtask : t_lock
	task automatic t_rate;
		model = MODEL_EXTENDED;
		fast = 1;
		next_out();
		t0 = ticks;
		next_out();
		`CHK(gap, DIV_HIGH)
		`CHK(ticks - t0, 1)
		fast = 0;
		next_out();
		next_out();
		`CHK(gap, DIV_LOW)
	endtask : t_rate
	task automatic finish_test;
		$display("mismatches=%0d checks=%0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (2) @(negedge clk);
		rst_b = 1;
		t_iir();
		t_lock();
		t_rate();
		finish_test();
	end
endmodule : ilf_iir_filter_tb
`default_nettype wire
